// ==== design/aarr_consts.svh ====
// constants for the aux converter round robin control
// assumes one 40 MHz clock; included by the package and every module but the settle timer
// Contract
// - one pin slot per round robin cycle; eight cycles cover eight pins.
// - after start, pin slot takes pin 1, then pin 3, then onward.
// - inactive pin slot is skipped but keeps its time in the cycle.
// - pin result updates only when one pin is locked; else 0x8000.
// - all twelve misc inputs convert in every cycle while running.
// - protector dac slots read the live threshold, never a copy.
// - a trigger write of one starts the converter; later edits wait.
// - trigger captures mode, selects, settling, cell count, pin setup.
// - a status output shows whether the converter is running.
// - misc ready sets once every misc input converted since trigger.
// - cell ready sets once each selected cell channel converted once.
// - pin ready sets after eight pin slots; inactive results dropped.
// - mode 0b00 stops; mode 0b01 runs one cycle then stops.
// - mode 0b10 runs until mode 0b00 is triggered.
// - mode 0b11 runs eight cycles then stops.
// - runs only when active; sleep freezes state, wake resumes it.
// - align 0: cell slot follows the main slot of its cell.
// - align 1: cell slot always meets main slot 12, cell 8.
// - cell select 00h loops active cells; 04h locks cell 3.
// - cell result updates only for valid lock after settling; else 0x8000.
// - settling select gives 4.3 ms, 2.3 ms or 1.3 ms waits.
`ifndef AARR_CONSTS_SVH
`define AARR_CONSTS_SVH
`define AARR_CLK_KHZ 40000
`define AARR_SETTLE0_MS 4.3
`define AARR_SETTLE1_MS 2.3
`define AARR_SETTLE2_MS 1.3
`define AARR_SETTLE_SEL0 2'h0
`define AARR_SETTLE_SEL1 2'h1
`define AARR_MODE_STOP 2'h0
`define AARR_MODE_SINGLE 2'h1
`define AARR_MODE_CONT 2'h2
`define AARR_MODE_BURST 2'h3
`define AARR_SLOT_FIRST 4'h0
`define AARR_SLOT_CELL 4'h5
`define AARR_SLOT_MISC_LAST 4'hc
`define AARR_SLOT_PIN 4'hd
`define AARR_SLOT_LAST 4'hd
`define AARR_BURST_LAST 4'h7
`define AARR_BURST_CNT 4'h8
`define AARR_RES_RST 16'h8000
`define AARR_CSEL_LOOP 5'h00
`define AARR_CSEL_OFS 5'h01
`define AARR_CH_FIRST 5'h01
`define AARR_CH_BB 5'h11
`define AARR_NCELL_MAX 5'h10
`define AARR_NCELL_ZERO 4'h0
`define AARR_PSEL_FIRST 4'h1
`define AARR_NPIN 4'h8
`define AARR_PIN_LAST_VISIT 4'h7
`define AARR_PINCFG_W 3
`define AARR_PIN_ADC 3'h1
`define AARR_PIN_ADC_TH 3'h2
`define AARR_MAIN_FIX_SLOT 5'h0c
`define AARR_MAIN_CELL_OFS 5'h04
`endif

// ==== design/aarr_pkg.sv ====
// shared types of the aux round robin control
// assumes aarr_consts.svh is on the include path
`include "aarr_consts.svh"
package aarr_pkg;
  typedef enum logic [1:0] {
    aarr_stop = `AARR_MODE_STOP,
    aarr_single = `AARR_MODE_SINGLE,
    aarr_cont = `AARR_MODE_CONT,
    aarr_burst = `AARR_MODE_BURST
  } aarr_mode_t;
  typedef enum logic [1:0] {
    aarr_idle,
    aarr_align,
    aarr_req,
    aarr_wait
  } aarr_state_t;
endpackage

// ==== design/aarr_settle_timer.sv ====
// filter settling down-counter
// assumes load and run come from the same clock domain
`timescale 1ns/1ps
module aarr_settle_timer #(
  parameter int TW = 18
)
(
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic load, // restart the wait
  input wire logic run, // count only while active
  input wire logic [TW-1:0] count, // wait in cycles
  output logic done // wait elapsed
);
  logic [TW-1:0] cnt_q;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      cnt_q <= '0;
    else if (load)
      cnt_q <= count;
    else if (run && cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;

  assign done = (cnt_q == '0);
endmodule

// ==== design/aarr_result_reg.sv ====
// 16-bit result holder that idles at the no-data code
// assumes clear and load never matter in the same cycle twice
`timescale 1ns/1ps
`include "aarr_consts.svh"
module aarr_result_reg (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic clear, // back to no-data code
  input wire logic load, // take din
  input wire logic [15:0] din, // conversion word
  output logic [7:0] res_high, // high byte
  output logic [7:0] res_low // low byte
);
  logic [15:0] res_q;

  // load wins over clear; aarr_ctrl masks slot_end on a restart, so a result landing then is dropped
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      res_q <= `AARR_RES_RST;
    else if (load)
      res_q <= din;
    else if (clear)
      res_q <= `AARR_RES_RST;

  assign res_high = res_q[15:8];
  assign res_low = res_q[7:0];
endmodule

// ==== design/aarr_ctrl.sv ====
// aux converter round robin sequencer: slot timing, config capture,
// channel stepping, results and ready flags
// assumes the converter answers each conv_req with one conv_done
`timescale 1ns/1ps
`include "aarr_consts.svh"
module aarr_ctrl
  import aarr_pkg::*;
#(
  parameter int CLK_KHZ = `AARR_CLK_KHZ,
  parameter int SETTLE0_CYC = int'(`AARR_SETTLE0_MS * CLK_KHZ),
  parameter int SETTLE1_CYC = int'(`AARR_SETTLE1_MS * CLK_KHZ),
  parameter int SETTLE2_CYC = int'(`AARR_SETTLE2_MS * CLK_KHZ),
  parameter int TW = 18
)
(
  input wire logic ref_clk, // 40 MHz clock
  input wire logic sys_rst, // async reset
  input wire logic aux_trigger, // go strobe
  input wire logic [1:0] aux_run_mode, // run mode
  input wire logic [4:0] aux_cell_channel_select, // cell lock or loop
  input wire logic [1:0] aux_filter_settling_select, // settling pick
  input wire logic [3:0] aux_pin_channel_select, // pin lock or loop
  input wire logic [3:0] highest_active_cell, // 0 means 16
  input wire logic [23:0] pin_function_config, // 3 bits per pin
  input wire logic aux_cell_align_fixed, // 1: fixed alignment
  input wire logic device_active, // low in sleep
  input wire logic [4:0] main_slot, // main converter slot now
  input wire logic conv_done, // conversion finished
  input wire logic [15:0] conv_data, // conversion word
  output logic conv_req, // start a conversion
  output logic [3:0] conv_slot, // slot being converted
  output logic [4:0] cell_input_selector, // cell mux channel
  output logic [2:0] pin_input_selector, // pin mux, 0 = pin 1
  output logic conv_used, // slot result is kept
  output logic aux_running, // converter running
  output logic misc_inputs_ready, // misc ready flag
  output logic cell_slot_ready, // cell ready flag
  output logic pin_slot_ready, // pin ready flag
  output logic [7:0] aux_cell_result_high, // cell result high
  output logic [7:0] aux_cell_result_low, // cell result low
  output logic [7:0] aux_pin_result_high, // pin result high
  output logic [7:0] aux_pin_result_low // pin result low
);
  aarr_state_t state_q;
  aarr_state_t state_d;
  aarr_mode_t mode_q;
  logic trig_q;
  logic trig_pulse;
  logic [4:0] csel_q;
  logic [1:0] settle_q;
  logic [3:0] psel_q;
  logic [4:0] ncell_q;
  logic [23:0] pcfg_q;
  logic align_fix_q;
  logic [3:0] slot_q;
  logic [3:0] cycles_q;
  logic [4:0] cell_ch_q;
  logic [4:0] cell_ch_nx;
  logic [2:0] pin_seq_q;
  logic [3:0] pin_visits_q;
  logic [2:0] pin_now;
  logic [2:0] pin_fn;
  logic [3:0] next_slot;
  logic [4:0] align_tgt;
  logic [1:0] settle_pick;
  logic [TW-1:0] settle_cnt;
  logic slot_end;
  logic cyc_end;
  logic last_cyc;
  logic cell_lock;
  logic ch_ok;
  logic settled;
  logic cell_conv;
  logic cell_step;
  logic pin_lock;
  logic pin_act;
  logic pin_slot_end;

  // one capture per rising edge, a held trigger does not re-arm
  assign trig_pulse = aux_trigger & ~trig_q;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      trig_q <= 1'b0;
    else
      trig_q <= aux_trigger;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      mode_q <= aarr_stop;
      csel_q <= `AARR_CSEL_LOOP;
      settle_q <= `AARR_SETTLE_SEL0;
      psel_q <= '0;
      ncell_q <= `AARR_NCELL_MAX;
      pcfg_q <= '0;
      align_fix_q <= 1'b0;
    end
    else if (trig_pulse)
    begin
      mode_q <= aarr_mode_t'(aux_run_mode);
      csel_q <= aux_cell_channel_select;
      settle_q <= aux_filter_settling_select;
      psel_q <= aux_pin_channel_select;
      ncell_q <= (highest_active_cell == `AARR_NCELL_ZERO) ?
        `AARR_NCELL_MAX : {1'b0, highest_active_cell};
      pcfg_q <= pin_function_config;
      align_fix_q <= aux_cell_align_fixed;
    end

  assign next_slot = (slot_q == `AARR_SLOT_LAST) ?
    `AARR_SLOT_FIRST : 4'(slot_q + 4'h1);
  // sleep freezes the sequence, including a pending conversion
  assign slot_end = (state_q == aarr_wait) && conv_done &&
    device_active && !trig_pulse;
  assign cyc_end = slot_end && (slot_q == `AARR_SLOT_LAST);
  assign last_cyc = (mode_q == aarr_single) ||
    (mode_q == aarr_burst && cycles_q == `AARR_BURST_LAST);

  always_comb
  begin
    state_d = state_q;
    if (trig_pulse)
      state_d = (aarr_mode_t'(aux_run_mode) == aarr_stop) ?
        aarr_idle : aarr_req;
    else if (device_active)
      unique case (state_q)
        aarr_idle:
          state_d = aarr_idle;
        aarr_align:
          if (main_slot == align_tgt)
            state_d = aarr_req;
        aarr_req:
          state_d = aarr_wait;
        aarr_wait:
          if (conv_done)
          begin
            if (cyc_end && last_cyc)
              state_d = aarr_idle;
            else if (next_slot == `AARR_SLOT_CELL)
              state_d = aarr_align;
            else
              state_d = aarr_req;
          end
      endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      state_q <= aarr_idle;
    else
      state_q <= state_d;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      slot_q <= `AARR_SLOT_FIRST;
    else if (trig_pulse)
      slot_q <= `AARR_SLOT_FIRST;
    else if (slot_end)
      slot_q <= next_slot;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      cycles_q <= '0;
    else if (trig_pulse)
      cycles_q <= '0;
    else if (cyc_end && cycles_q != `AARR_BURST_CNT)
      cycles_q <= 4'(cycles_q + 4'h1);

  assign conv_req = (state_q == aarr_req) && device_active;
  assign conv_slot = slot_q;
  assign aux_running = (state_q != aarr_idle);

  // dynamic target tracks the cell in the mux; bus-bar uses the fixed one
  assign align_tgt = (align_fix_q || cell_ch_q == `AARR_CH_BB) ?
    `AARR_MAIN_FIX_SLOT :
    5'(cell_ch_q + `AARR_MAIN_CELL_OFS);

  assign cell_lock = (csel_q != `AARR_CSEL_LOOP);
  assign ch_ok = (cell_ch_q == `AARR_CH_BB) ||
    (cell_ch_q >= `AARR_CH_FIRST && cell_ch_q <= ncell_q);
  assign cell_ch_nx = (cell_ch_q == `AARR_CH_BB) ? `AARR_CH_FIRST :
    (cell_ch_q >= ncell_q) ? `AARR_CH_BB : 5'(cell_ch_q + 5'h01);

  // an unsettled cell slot still runs so the cycle keeps its length
  assign cell_conv = slot_end && (slot_q == `AARR_SLOT_CELL) &&
    settled && ch_ok;
  assign cell_step = cell_conv && !cell_lock;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      cell_ch_q <= `AARR_CH_FIRST;
    else if (trig_pulse)
      cell_ch_q <= (aux_cell_channel_select == `AARR_CSEL_LOOP) ?
        `AARR_CH_FIRST :
        5'(aux_cell_channel_select - `AARR_CSEL_OFS);
    else if (cell_step)
      cell_ch_q <= cell_ch_nx;

  assign settle_pick = trig_pulse ? aux_filter_settling_select : settle_q;

  always_comb
    unique case (settle_pick)
      `AARR_SETTLE_SEL0: settle_cnt = TW'(SETTLE0_CYC);
      `AARR_SETTLE_SEL1: settle_cnt = TW'(SETTLE1_CYC);
      default: settle_cnt = TW'(SETTLE2_CYC);
    endcase

  aarr_settle_timer #(
    .TW(TW)
  ) u_settle (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load(trig_pulse || cell_step),
    .run(device_active),
    .count(settle_cnt),
    .done(settled)
  );

  aarr_result_reg u_cell_res (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(trig_pulse),
    .load(cell_conv && cell_lock),
    .din(conv_data),
    .res_high(aux_cell_result_high),
    .res_low(aux_cell_result_low)
  );

  // pins out of 1..8 in the select behave as loop
  assign pin_lock = (psel_q >= `AARR_PSEL_FIRST) &&
    (psel_q <= `AARR_NPIN);
  // loop order 1,3,5,7,2,4,6,8 by bit-rotating the sequence count
  assign pin_now = pin_lock ? 3'(psel_q - `AARR_PSEL_FIRST) :
    {pin_seq_q[1:0], pin_seq_q[2]};
  assign pin_fn = pcfg_q[`AARR_PINCFG_W * pin_now +: `AARR_PINCFG_W];
  assign pin_act = (pin_fn == `AARR_PIN_ADC) ||
    (pin_fn == `AARR_PIN_ADC_TH);
  assign pin_slot_end = slot_end && (slot_q == `AARR_SLOT_PIN);

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      pin_seq_q <= '0;
    else if (trig_pulse)
      pin_seq_q <= '0;
    else if (pin_slot_end && !pin_lock)
      pin_seq_q <= 3'(pin_seq_q + 3'h1);

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      pin_visits_q <= '0;
    else if (trig_pulse)
      pin_visits_q <= '0;
    else if (pin_slot_end && pin_visits_q != `AARR_NPIN)
      pin_visits_q <= 4'(pin_visits_q + 4'h1);

  aarr_result_reg u_pin_res (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(trig_pulse),
    .load(pin_slot_end && pin_lock && pin_act),
    .din(conv_data),
    .res_high(aux_pin_result_high),
    .res_low(aux_pin_result_low)
  );

  // protector dac slots sample the live threshold, nothing is latched
  assign conv_used = (slot_q == `AARR_SLOT_CELL) ? (settled && ch_ok) :
    (slot_q == `AARR_SLOT_PIN) ? pin_act : 1'b1;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      cell_input_selector <= `AARR_CH_FIRST;
      pin_input_selector <= '0;
    end
    else
    begin
      cell_input_selector <= cell_ch_q;
      pin_input_selector <= pin_now;
    end

  // a restart clears; slot_end is masked in that cycle, so no old-run slot end can set it
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      misc_inputs_ready <= 1'b0;
    else if (slot_end && slot_q == `AARR_SLOT_MISC_LAST)
      misc_inputs_ready <= 1'b1;
    else if (trig_pulse)
      misc_inputs_ready <= 1'b0;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      cell_slot_ready <= 1'b0;
    else if (cell_conv && (cell_lock || cell_ch_q == `AARR_CH_BB))
      cell_slot_ready <= 1'b1;
    else if (trig_pulse)
      cell_slot_ready <= 1'b0;

  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      pin_slot_ready <= 1'b0;
    else if (pin_slot_end && pin_visits_q == `AARR_PIN_LAST_VISIT)
      pin_slot_ready <= 1'b1;
    else if (trig_pulse)
      pin_slot_ready <= 1'b0;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_go_run;
    trig_pulse && aux_run_mode != `AARR_MODE_STOP;
  endsequence

  // request for slot 0 stands in the first running cycle, then it waits
  sequence s_first_slots;
    aux_running && slot_q == `AARR_SLOT_FIRST &&
      (conv_req || !device_active) ##1 aux_running;
  endsequence

  chk_go_starts: assert property (
    s_go_run |=> s_first_slots)
    else $error("trigger did not start slot 0");
  chk_pin_step: assert property (
    pin_slot_end && !pin_lock |=>
      pin_seq_q == 3'($past(pin_seq_q) + 3'h1))
    else $error("pin sequence did not advance by one");
  chk_pin_order: assert property (
    !pin_lock && pin_seq_q == 3'h1 |-> pin_now == 3'h2)
    else $error("second pin slot is not pin 3");
  chk_pin_skip: assert property (
    pin_slot_end && !pin_act |=>
      $stable({aux_pin_result_high, aux_pin_result_low}))
    else $error("inactive pin slot changed the pin result");
  chk_pin_result: assert property (
    !pin_lock && !trig_pulse |->
      {aux_pin_result_high, aux_pin_result_low} == `AARR_RES_RST)
    else $error("pin result moved while looping");
  chk_misc_ready: assert property (
    $rose(misc_inputs_ready) |->
      $past(slot_q) == `AARR_SLOT_MISC_LAST && $past(slot_end))
    else $error("misc ready set early");
  chk_pin_ready: assert property (
    $rose(pin_slot_ready) |-> $past(pin_visits_q) == `AARR_PIN_LAST_VISIT)
    else $error("pin ready not after eight visits");
  chk_single_stop: assert property (
    cyc_end && mode_q == aarr_single |=> !aux_running || $past(trig_pulse))
    else $error("single mode did not stop");
  chk_cont_runs: assert property (
    cyc_end && mode_q == aarr_cont |=> aux_running)
    else $error("continuous mode stopped");
  chk_sleep_hold: assert property (
    !device_active && !trig_pulse |=> $stable(slot_q) && $stable(state_q))
    else $error("sequence moved during sleep");
  chk_fixed_align: assert property (
    state_q == aarr_align && align_fix_q && device_active &&
      main_slot == `AARR_MAIN_FIX_SLOT && !trig_pulse |=>
      conv_req || !device_active)
    else $error("cell slot missed main slot 12");
  chk_cell_result: assert property (
    !cell_lock && !trig_pulse |->
      {aux_cell_result_high, aux_cell_result_low} == `AARR_RES_RST)
    else $error("cell result moved while looping");
endmodule

// ==== tb/aarr_ctrl_tb.sv ====
// self-checking bench for the aux round robin sequencer
// assumes aarr_ctrl with shortened settling counts; bench answers conversions
`timescale 1ns/1ps
`include "aarr_consts.svh"
module aarr_ctrl_tb
  import aarr_pkg::*;
;
  logic ref_clk, sys_rst, aux_trigger, aux_cell_align_fixed, device_active;
  logic [1:0] aux_run_mode, aux_filter_settling_select;
  logic [4:0] aux_cell_channel_select, main_slot, cell_input_selector;
  logic [3:0] aux_pin_channel_select, highest_active_cell, conv_slot;
  logic [23:0] pin_function_config;
  logic conv_done, conv_req, conv_used, aux_running;
  logic [15:0] conv_data;
  logic [2:0] pin_input_selector;
  logic misc_inputs_ready, cell_slot_ready, pin_slot_ready;
  logic [7:0] cell_hi, cell_lo, pin_hi, pin_lo;
  int error_cnt, comparisons, req_cnt, pend, exp_slot, pin_visit, lock_pin;
  int cell_exp, n;
  logic trig_q;
  logic fire;
  // align_exp: main slot seen with the cell request, one past the target
  int pin_on = 0, cell_loop = 0, align_exp = 13;
  logic [2:0] pin_order [8] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1, 3'h3, 3'h5, 3'h7};

  aarr_ctrl #(.SETTLE0_CYC(20), .SETTLE1_CYC(10), .SETTLE2_CYC(5)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .aux_trigger(aux_trigger),
    .aux_run_mode(aux_run_mode),
    .aux_cell_channel_select(aux_cell_channel_select),
    .aux_filter_settling_select(aux_filter_settling_select),
    .aux_pin_channel_select(aux_pin_channel_select),
    .highest_active_cell(highest_active_cell),
    .pin_function_config(pin_function_config),
    .aux_cell_align_fixed(aux_cell_align_fixed),
    .device_active(device_active), .main_slot(main_slot),
    .conv_done(conv_done), .conv_data(conv_data), .conv_req(conv_req),
    .conv_slot(conv_slot), .cell_input_selector(cell_input_selector),
    .pin_input_selector(pin_input_selector), .conv_used(conv_used),
    .aux_running(aux_running), .misc_inputs_ready(misc_inputs_ready),
    .cell_slot_ready(cell_slot_ready), .pin_slot_ready(pin_slot_ready),
    .aux_cell_result_high(cell_hi), .aux_cell_result_low(cell_lo),
    .aux_pin_result_high(pin_hi), .aux_pin_result_low(pin_lo)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results();
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, well above the longest run of all scenarios
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    results();
  end

  // free-running main slot so every alignment target comes round
  always @(posedge ref_clk)
    main_slot <= main_slot + 5'h01;

  // converter stand-in and slot monitor; answers only while awake
  always @(posedge ref_clk)
  begin
    fire = 1'b0;
    if (aux_trigger && !trig_q)
    begin
      exp_slot = 0;
      pin_visit = 0;
    end
    trig_q = aux_trigger;
    if (conv_done === 1'b1 && conv_slot === `AARR_SLOT_PIN)
    begin
      check({13'h0, pin_input_selector}, (lock_pin == 0) ?
        {13'h0, pin_order[pin_visit]} : 16'(lock_pin - 1));
      check({15'h0, conv_used}, 16'(pin_on));
      pin_visit = (pin_visit + 1) % 8;
    end
    else if (conv_done === 1'b1 && conv_slot !== `AARR_SLOT_CELL)
      check({15'h0, conv_used}, 16'h0001);
    if (conv_done === 1'b1 && conv_slot === `AARR_SLOT_CELL && cell_exp != 0)
    begin
      check({11'h0, cell_input_selector}, 16'(cell_exp));
      cell_exp = cell_exp + cell_loop;
    end
    if (conv_req === 1'b1 && conv_slot === `AARR_SLOT_CELL)
      check({11'h0, main_slot}, 16'(align_exp));
    if (conv_req === 1'b1)
    begin
      check({12'h0, conv_slot}, 16'(exp_slot));
      exp_slot = (exp_slot == 13) ? 0 : exp_slot + 1;
      req_cnt++;
      pend = 3;
    end
    else if (pend > 0 && device_active)
    begin
      pend--;
      fire = (pend == 0);
    end
    conv_done <= fire;
    if (fire)
      conv_data <= {4'h5, conv_slot, 8'h3c};
  end

  task go(input logic [1:0] m, input logic [4:0] cs, input logic [3:0] ps,
    input logic [23:0] pc, input logic al, input logic hold);
    req_cnt = 0;
    // no thermistor pins here; a bench using them turns the reference on first
    @(posedge ref_clk);
    aux_run_mode <= m;
    aux_cell_channel_select <= cs;
    aux_pin_channel_select <= ps;
    pin_function_config <= pc;
    aux_cell_align_fixed <= al;
    aux_trigger <= 1'b1;
    @(posedge ref_clk);
    aux_trigger <= hold;
    repeat (3) @(posedge ref_clk);
  endtask

  task wait_idle();
    while (aux_running !== 1'b0)
      @(posedge ref_clk);
  endtask

  task check_out(input logic [15:0] pin_r, input logic [15:0] cell_r,
    input logic [2:0] flags);
    check({pin_hi, pin_lo}, pin_r);
    check({cell_hi, cell_lo}, cell_r);
    check({13'h0, misc_inputs_ready, cell_slot_ready, pin_slot_ready},
      {13'h0, flags});
  endtask

  initial
  begin
    sys_rst = 1'b1;
    aux_trigger = 1'b0;
    aux_run_mode = `AARR_MODE_STOP;
    aux_cell_channel_select = `AARR_CSEL_LOOP;
    aux_filter_settling_select = `AARR_SETTLE_SEL1;
    aux_pin_channel_select = 4'h0;
    highest_active_cell = 4'h0;
    pin_function_config = 24'h000000;
    aux_cell_align_fixed = 1'b1;
    device_active = 1'b1;
    main_slot = 5'h00;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    trig_q = 1'b0;
    {error_cnt, comparisons, req_cnt, pend, lock_pin, cell_exp} = '0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check_out(`AARR_RES_RST, `AARR_RES_RST, 3'h0);
    check({15'h0, aux_running}, 16'h0000);
    // single cycle, trigger left high: one start only
    go(`AARR_MODE_SINGLE, `AARR_CSEL_LOOP, 4'h0, 24'h000000, 1'b1, 1'b1);
    check({15'h0, aux_running}, 16'h0001);
    wait_idle();
    check(16'(req_cnt), 16'd14);
    check_out(`AARR_RES_RST, `AARR_RES_RST, 3'h4);
    repeat (40) @(posedge ref_clk);
    check({15'h0, aux_running}, 16'h0000);
    aux_trigger <= 1'b0;
    // eight cycles, pin 3 locked and active, cell 3 locked
    lock_pin = 3;
    cell_exp = 3;
    pin_on = 1;
    go(`AARR_MODE_BURST, 5'h04, 4'h3, 24'h000040, 1'b1, 1'b0);
    wait_idle();
    check(16'(req_cnt), 16'd112);
    check_out(16'h5d3c, 16'h553c, 3'h7);
    // pin 3 locked but inactive, invalid cell lock, dynamic alignment
    // select 01h gives channel 0, so the dynamic target is main slot 4
    cell_exp = 0;
    pin_on = 0;
    align_exp = 5;
    aux_filter_settling_select <= 2'h2;
    go(`AARR_MODE_BURST, 5'h01, 4'h3, 24'h000000, 1'b0, 1'b0);
    wait_idle();
    check(16'(req_cnt), 16'd112);
    check_out(`AARR_RES_RST, `AARR_RES_RST, 3'h5);
    // continuous loop; later edits without a go must be ignored
    // short settling: the loop steps one cell on every cycle
    lock_pin = 0;
    align_exp = 13;
    cell_exp = 1;
    cell_loop = 1;
    go(`AARR_MODE_CONT, `AARR_CSEL_LOOP, 4'h0, 24'hffffff, 1'b1, 1'b0);
    while (req_cnt < 14 * 9)
      @(posedge ref_clk);
    aux_pin_channel_select <= 4'h2;
    pin_function_config <= 24'h000008;
    while (req_cnt < 14 * 11)
      @(posedge ref_clk);
    check({pin_hi, pin_lo}, `AARR_RES_RST);
    check({15'h0, pin_slot_ready}, 16'h0001);
    // sleep right after a request so no answer is in flight
    @(posedge ref_clk iff conv_req === 1'b1);
    device_active <= 1'b0;
    // read one edge later, once the monitor has surely counted this request
    @(posedge ref_clk);
    n = req_cnt;
    repeat (60) @(posedge ref_clk);
    check(16'(req_cnt), 16'(n));
    device_active <= 1'b1;
    repeat (40) @(posedge ref_clk);
    check({15'h0, req_cnt > n}, 16'h0001);
    // stop just after a request so no answer lands in the go cycle
    @(posedge ref_clk iff conv_req === 1'b1);
    go(`AARR_MODE_STOP, `AARR_CSEL_LOOP, 4'h0, 24'h000000, 1'b1, 1'b0);
    check({15'h0, aux_running}, 16'h0000);
    repeat (10) @(posedge ref_clk);
    results();
  end
endmodule
